// >>> rtl/dog_regs.svh
// Register map, field positions, reset values and timing counts of the
// watchdog and sleep control block.
// Assumes a 32-bit APB with byte addresses; each register is one aligned word.
`ifndef DOG_REGS_SVH
`define DOG_REGS_SVH

// --------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// --------------------------------------------------------------------------
`define POWER_CONTROL_INDEX     10'h087
`define DOG_CONTROL_INDEX       10'h088
`define RESET_CONFIG_INDEX      10'h089

// --------------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------------
`define DCS_SERVICE_BIT         0
`define DCS_FLAG_BIT            6
`define DCS_ENABLE_BIT          7
`define PWR_SLEEP_BIT           0
`define PWR_FLAGS_LSB           2
`define PWR_FLAGS_MSB           3
`define PWR_BAUD_BIT            7
`define CFG_USB_RST_EN_BIT      0

// --------------------------------------------------------------------------
// Reset values, watchdog counter width and last count
// --------------------------------------------------------------------------
`define DOG_CONTROL_RESET       8'h00
`define POWER_CONTROL_RESET     8'h00
`define RESET_CONFIG_RESET      8'h00
`define DOG_COUNT_WIDTH         5
`define DOG_LAST_COUNT          5'h1f

// --------------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------------
`define SYS_CLK_PERIOD_NS       4
`define DOG_TICK_NS             1000000
`define WAKE_HOLD_NS            400000
`define DOG_TICK_CYCLES         (`DOG_TICK_NS / `SYS_CLK_PERIOD_NS)
`define WAKE_HOLD_CYCLES        ((`WAKE_HOLD_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)

`endif

// >>> rtl/dog_pkg.sv
// Types shared by the watchdog and sleep control block.
// Assumes nothing beyond a SystemVerilog compiler.
package dog_pkg;

    // Power state driven to the clock, RAM and UART logic
    typedef struct packed {
        logic       ram_low_power;
        logic       osc_stop;
        logic       baud_doubler;
        logic [1:0] general_flags;
    } power_out_t;

endpackage

// >>> rtl/level_hold_detector.sv
// Detects a level held high for a minimum number of consecutive cycles.
// Assumes the level input is already synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none

module level_hold_detector #(
    parameter int HOLD_CYCLES = 100000
) (
    // Clock, reset, enable
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic ce,
    // Level in, detection out
    input  wire logic level,
    output logic      fired
);

    localparam int CW = $clog2(HOLD_CYCLES + 1);

    if (HOLD_CYCLES < 2) begin : g_bad_hold
        $error("HOLD_CYCLES must be at least 2");
    end

    logic [CW-1:0] hold_count;
    logic [CW-1:0] next_hold_count;
    logic          next_fired;

    // Saturates after firing so one long press gives one pulse
    always_comb begin
        next_hold_count = hold_count;
        next_fired      = 1'b0;
        if (!level) begin
            next_hold_count = '0;
        end else if (hold_count != CW'(HOLD_CYCLES)) begin
            next_hold_count = hold_count + CW'(1);
            next_fired      = (hold_count == CW'(HOLD_CYCLES - 1));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hold_count <= '0;
            fired      <= 1'b0;
        end else if (ce) begin
            hold_count <= next_hold_count;
            fired      <= next_fired;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_hold_full: assert property (
        fired |-> hold_count == CW'(HOLD_CYCLES) && $past(level))
        else $error("wake fired before the full hold time");

endmodule

`default_nettype wire

// >>> rtl/dog_and_sleep_control.sv
// Watchdog timer and sleep control of the embedded controller, APB slave.
// Assumes all inputs synchronous to sys_clk; sof_detected is a pulse per
// USB start-of-frame, usb_reset a level from the USB core.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dog_regs.svh"

module dog_and_sleep_control #(
    parameter int TICK_CYCLES = `DOG_TICK_CYCLES,
    parameter int WAKE_CYCLES = `WAKE_HOLD_CYCLES
) (
    // Clock, reset, enable
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               ce,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // USB and wake events
    input  wire logic               sof_detected,
    input  wire logic               usb_reset,
    input  wire logic               wake_interrupt_line,
    // Controller reset, wake interrupt, power state
    output logic                    mcu_reset,
    output logic                    wake_irq,
    output dog_pkg::power_out_t     power_out
);

    localparam int TW = $clog2(TICK_CYCLES);
    localparam int CW = `DOG_COUNT_WIDTH;
    localparam logic [11:0] PWR_ADDR = {`POWER_CONTROL_INDEX, 2'b00};
    localparam logic [11:0] DCS_ADDR = {`DOG_CONTROL_INDEX, 2'b00};
    localparam logic [11:0] CFG_ADDR = {`RESET_CONFIG_INDEX, 2'b00};

    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("TICK_CYCLES must be at least 2");
    end

    // ----------------------------------------------------------------------
    // State
    // ----------------------------------------------------------------------
    logic [TW-1:0] tick_div;
    logic [CW-1:0] dog_count;
    logic          dog_enable;
    logic          dog_reset_flag;
    logic          sof_seen;
    logic          sleep_request;
    logic [1:0]    general_flags;
    logic          baud_doubler;
    logic          usb_reset_enable;
    logic          read_valid;

    logic [TW-1:0] next_tick_div;
    logic [CW-1:0] next_dog_count;
    logic          next_dog_enable;
    logic          next_dog_reset_flag;
    logic          next_sof_seen;
    logic          next_sleep_request;
    logic [1:0]    next_general_flags;
    logic          next_baud_doubler;
    logic          next_usb_reset_enable;
    logic          next_read_valid;
    logic          next_mcu_reset;
    logic          next_wake_irq;
    logic [31:0]   next_prdata;

    // ----------------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------------
    logic hit_pwr;
    logic hit_dcs;
    logic hit_cfg;
    logic mapped;
    logic wr_pwr;
    logic wr_dcs;
    logic wr_cfg;
    logic [7:0] read_byte;

    assign hit_pwr = (paddr == PWR_ADDR);
    assign hit_dcs = (paddr == DCS_ADDR);
    assign hit_cfg = (paddr == CFG_ADDR);
    assign mapped  = hit_pwr | hit_dcs | hit_cfg;
    // Read data is captured a cycle ahead, so a frozen clock enable delays pready
    assign pready  = psel & penable & ce & read_valid;
    assign pslverr = pready & ~mapped;
    assign wr_pwr  = pready & pwrite & hit_pwr;
    assign wr_dcs  = pready & pwrite & hit_dcs;
    assign wr_cfg  = pready & pwrite & hit_cfg;

    always_comb begin
        read_byte = 8'h00;
        if (hit_dcs) begin
            read_byte[`DCS_ENABLE_BIT] = dog_enable;
            read_byte[`DCS_FLAG_BIT]   = dog_reset_flag;
        end else if (hit_pwr) begin
            read_byte[`PWR_BAUD_BIT]  = baud_doubler;
            read_byte[`PWR_FLAGS_MSB:`PWR_FLAGS_LSB] = general_flags;
            read_byte[`PWR_SLEEP_BIT] = sleep_request;
        end else if (hit_cfg) begin
            read_byte[`CFG_USB_RST_EN_BIT] = usb_reset_enable;
        end
    end

    // ----------------------------------------------------------------------
    // Watchdog and sleep control
    // ----------------------------------------------------------------------
    logic wake_seen;
    logic wake_now;
    logic usb_clear;
    logic tick;
    logic run;
    logic service;
    logic expire;

    level_hold_detector #(
        .HOLD_CYCLES (WAKE_CYCLES)
    ) u_wake_hold (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ce      (ce),
        .level   (wake_interrupt_line),
        .fired   (wake_seen)
    );

    assign usb_clear = usb_reset & usb_reset_enable;
    assign wake_now  = wake_seen & sleep_request;
    assign tick      = (tick_div == TW'(TICK_CYCLES - 1));
    assign run       = dog_enable & sof_seen & ~sleep_request;
    assign service   = wr_dcs & pwdata[`DCS_SERVICE_BIT];
    assign expire    = run & tick & (dog_count == `DOG_LAST_COUNT) & ~service;

    always_comb begin
        // Time base stops with the oscillator during sleep
        next_tick_div = tick_div;
        if (!sleep_request) begin
            next_tick_div = tick ? '0 : tick_div + TW'(1);
        end

        next_dog_count = dog_count;
        if (!dog_enable || service || expire || usb_clear) begin
            next_dog_count = '0;
        end else if (run && tick) begin
            next_dog_count = dog_count + CW'(1);
        end

        // Writing zero cannot disable; expiry leaves enable alone
        next_dog_enable = dog_enable;
        if (usb_clear) begin
            next_dog_enable = 1'b0;
        end else if (wr_dcs && pwdata[`DCS_ENABLE_BIT]) begin
            next_dog_enable = 1'b1;
        end

        // Expiry wins over a written flag clear in the same cycle; usb_clear wins over both
        next_dog_reset_flag = dog_reset_flag;
        if (usb_clear) begin
            next_dog_reset_flag = 1'b0;
        end else if (expire) begin
            next_dog_reset_flag = 1'b1;
        end else if (wr_dcs && pwdata[`DCS_FLAG_BIT]) begin
            next_dog_reset_flag = 1'b0;
        end

        next_sof_seen = usb_clear ? 1'b0 : (sof_seen | sof_detected);

        // Wake wins so a sleep set never swallows a pending wake
        next_sleep_request = sleep_request;
        if (wake_now) begin
            next_sleep_request = 1'b0;
        end else if (wr_pwr && pwdata[`PWR_SLEEP_BIT]) begin
            next_sleep_request = 1'b1;
        end

        next_general_flags = wr_pwr ? pwdata[`PWR_FLAGS_MSB:`PWR_FLAGS_LSB] : general_flags;
        next_baud_doubler  = wr_pwr ? pwdata[`PWR_BAUD_BIT] : baud_doubler;
        next_usb_reset_enable = wr_cfg ? pwdata[`CFG_USB_RST_EN_BIT] : usb_reset_enable;

        next_mcu_reset  = expire;
        next_wake_irq   = wake_now;
        next_read_valid = psel & ~pready;
        next_prdata     = psel ? {24'h000000, read_byte} : prdata;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tick_div         <= '0;
            dog_count        <= '0;
            dog_enable       <= 1'(`DOG_CONTROL_RESET >> `DCS_ENABLE_BIT);
            dog_reset_flag   <= 1'b0;
            sof_seen         <= 1'b0;
            sleep_request    <= 1'b0;
            general_flags    <= 2'h0;
            baud_doubler     <= 1'b0;
            usb_reset_enable <= 1'b0;
            read_valid       <= 1'b0;
            mcu_reset        <= 1'b0;
            wake_irq         <= 1'b0;
            prdata           <= 32'h00000000;
        end else if (ce) begin
            tick_div         <= next_tick_div;
            dog_count        <= next_dog_count;
            dog_enable       <= next_dog_enable;
            dog_reset_flag   <= next_dog_reset_flag;
            sof_seen         <= next_sof_seen;
            sleep_request    <= next_sleep_request;
            general_flags    <= next_general_flags;
            baud_doubler     <= next_baud_doubler;
            usb_reset_enable <= next_usb_reset_enable;
            read_valid       <= next_read_valid;
            mcu_reset        <= next_mcu_reset;
            wake_irq         <= next_wake_irq;
            prdata           <= next_prdata;
        end
    end

    // RAM and oscillator follow the sleep bit directly
    assign power_out.ram_low_power = sleep_request;
    assign power_out.osc_stop      = sleep_request;
    assign power_out.baud_doubler  = baud_doubler;
    assign power_out.general_flags = general_flags;

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_tick_advance: assert property (
        ce && run && tick && !expire && !service && !usb_clear
        |=> dog_count == $past(dog_count) + CW'(1))
        else $error("watchdog did not advance on tick");

    chk_sof_gate: assert property (
        !sof_seen |-> dog_count == '0)
        else $error("watchdog counted before start-of-frame");

    chk_expiry_reset: assert property (
        ce && expire && !usb_clear |=> mcu_reset && dog_reset_flag && dog_count == '0)
        else $error("expiry did not reset controller");

    chk_service_zero: assert property (
        ce && service && !usb_clear |=> dog_count == '0 && !mcu_reset)
        else $error("service did not restart counter");

    chk_sleep_freeze: assert property (
        sleep_request && !usb_clear && !service |=> dog_count == $past(dog_count))
        else $error("watchdog moved during sleep");

    chk_enable_kept: assert property (
        mcu_reset && !$past(usb_clear) |-> dog_enable)
        else $error("watchdog reset dropped enable");

    chk_enable_start: assert property (
        ce && wr_dcs && pwdata[`DCS_ENABLE_BIT] && !usb_clear |=> dog_enable)
        else $error("enable write ignored");

    chk_flag_clear: assert property (
        ce && wr_dcs && pwdata[`DCS_FLAG_BIT] && !expire && !usb_clear |=> !dog_reset_flag)
        else $error("flag clear ignored");

    chk_reserved_zero: assert property (
        pready && hit_dcs && !pwrite |-> prdata[5:0] == 6'h00 && prdata[31:8] == 24'h000000)
        else $error("reserved control bits not zero");

    chk_wake_clears: assert property (
        $fell(sleep_request) |-> $past(wake_seen))
        else $error("sleep cleared without wake");

    chk_wake_irq: assert property (
        wake_irq |-> !sleep_request && $past(sleep_request) && !power_out.osc_stop)
        else $error("wake interrupt without leaving sleep");

    chk_disabled_zero: assert property (
        !dog_enable |-> dog_count == '0)
        else $error("counter nonzero while disabled");

endmodule

`default_nettype wire

// >>> bench/host_side_model.sv
// Model of the far side: USB frame source and the wake line driver.
// Assumes it shares sys_clk and rst with the block and is commanded by the bench.
`timescale 1ns/1ps
`default_nettype none

module host_side_model #(
    parameter int FRAME_CYCLES = 50
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Commands from the bench
    input  wire logic        frames_on,
    input  wire logic        wake_start,
    input  wire logic [15:0] wake_len,
    // Lines toward the block
    output logic             sof_detected,
    output logic             wake_interrupt_line
);
    int          frame_cnt;
    logic [15:0] wake_left;

    // ----------------------------------------------------------------------
    // Frame pulses
    // ----------------------------------------------------------------------
    // No frames until the bench starts the bus, so the dog must stay still
    always_ff @(posedge sys_clk) begin
        if (rst || !frames_on) begin
            frame_cnt <= 0;
        end else begin
            frame_cnt <= (frame_cnt == FRAME_CYCLES - 1) ? 0 : frame_cnt + 1;
        end
    end
    assign sof_detected = frames_on && (frame_cnt == FRAME_CYCLES - 1);

    // ----------------------------------------------------------------------
    // Wake line
    // ----------------------------------------------------------------------
    // Held high for exactly wake_len cycles, short holds probe the filter
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wake_left <= 16'h0000;
        end else if (wake_start) begin
            wake_left <= wake_len;
        end else if (wake_left != 16'h0000) begin
            wake_left <= wake_left - 16'h0001;
        end
    end
    assign wake_interrupt_line = (wake_left != 16'h0000);
endmodule

`default_nettype wire

// >>> bench/tb_dog_and_sleep_control.sv
// Self-checking testbench of the watchdog and sleep control block.
// Assumes the design under rtl/ and the host side model; short tick and wake counts.
`timescale 1ns/1ps
`default_nettype none
`include "dog_regs.svh"
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end

module tb_dog_and_sleep_control;
    localparam int          T   = 8;
    localparam int          W   = 4;
    localparam logic [11:0] PWR = {`POWER_CONTROL_INDEX, 2'b00};
    localparam logic [11:0] DCS = {`DOG_CONTROL_INDEX, 2'b00};
    localparam logic [11:0] CFG = {`RESET_CONFIG_INDEX, 2'b00};
    localparam logic [11:0] BAD = 12'h228;

    logic                sys_clk    = 1'b0;
    logic                rst        = 1'b1;
    logic                ce         = 1'b1;
    logic                psel       = 1'b0;
    logic                penable    = 1'b0;
    logic                pwrite     = 1'b0;
    logic [11:0]         paddr      = 12'h000;
    logic [31:0]         pwdata     = 32'h0;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                usb_reset  = 1'b0;
    logic                frames_on  = 1'b0;
    logic                wake_start = 1'b0;
    logic [15:0]         wake_len   = 16'h0000;
    logic                sof_detected;
    logic                wake_interrupt_line;
    logic                mcu_reset;
    logic                wake_irq;
    dog_pkg::power_out_t power_out;
    int                  error_cnt  = 0;
    int                  checked    = 0;
    int                  rst_cnt    = 0;
    int                  irq_cnt    = 0;
    int                  cycles     = 0;
    int                  n;
    time                 t0;
    logic [31:0]         rd;
    logic                err;

    always #2 sys_clk = ~sys_clk;

    dog_and_sleep_control #(.TICK_CYCLES(T), .WAKE_CYCLES(W)) dut (
        .sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sof_detected(sof_detected),
        .usb_reset(usb_reset), .wake_interrupt_line(wake_interrupt_line),
        .mcu_reset(mcu_reset), .wake_irq(wake_irq), .power_out(power_out));

    host_side_model #(.FRAME_CYCLES(50)) partner (
        .sys_clk(sys_clk), .rst(rst), .frames_on(frames_on), .wake_start(wake_start),
        .wake_len(wake_len), .sof_detected(sof_detected),
        .wake_interrupt_line(wake_interrupt_line));

    // ----------------------------------------------------------------------
    // Event counters and hang guard
    // ----------------------------------------------------------------------
    always @(posedge sys_clk) begin
        cycles++;
        if (mcu_reset === 1'b1) rst_cnt++;
        if (wake_irq === 1'b1) irq_cnt++;
        if (cycles == 20000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------------
    // APB master
    // ----------------------------------------------------------------------
    task automatic apb(input logic wr_en, input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= wr_en;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        // No local limit: only the cycle ceiling ends a hung access
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input string nm, input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK(nm, {24'h0, e}, rd)
    endtask

    // Waits for a watchdog expiry, bounded, and returns cycles since t0
    task automatic wait_dog();
        n = 0;
        while (mcu_reset !== 1'b1 && n < 2000) begin
            n++;
            @(posedge sys_clk);
        end
        n = int'(($time - t0) / 4);
    endtask

    // ----------------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        rdchk("power reset", PWR, 8'h00);
        rdchk("dog reset", DCS, 8'h00);
        rdchk("config reset", CFG, 8'h00);
        rdchk("unmapped", BAD, 8'h00);
        `CHK("unmapped err", 1'b1, err)
        wr(PWR, 8'hfe);
        rdchk("power rw", PWR, 8'h8c);
        #1;
        `CHK("baud out", 1'b1, power_out.baud_doubler)
        `CHK("flags out", 2'b11, power_out.general_flags)
        wr(PWR, 8'h00);
        rdchk("power clear", PWR, 8'h00);
        wr(DCS, 8'h3e);
        rdchk("dog reserved", DCS, 8'h00);
        wr(DCS, 8'h81);
        rdchk("dog enabled", DCS, 8'h80);
        repeat (40 * T) @(posedge sys_clk);
        `CHK("no frame no expiry", 0, rst_cnt)
        frames_on <= 1'b1;
        repeat (8) begin
            wr(DCS, 8'h01);
            repeat (20 * T) @(posedge sys_clk);
        end
        `CHK("serviced no expiry", 0, rst_cnt)
        wr(DCS, 8'h01);
        t0 = $time;
        repeat (16 * T) @(posedge sys_clk);
        wr(DCS, 8'h80);
        wait_dog();
        `CHK("expiry window", 1'b1, n >= 31 * T && n <= 32 * T + 3)
        `CHK("expiry pulse", 1'b1, mcu_reset)
        rdchk("flag set", DCS, 8'hc0);
        wr(DCS, 8'h80);
        rdchk("flag kept", DCS, 8'hc0);
        wr(DCS, 8'h40);
        rdchk("flag cleared", DCS, 8'h80);
        wr(DCS, 8'h01);
        wr(PWR, 8'h01);
        #1;
        `CHK("osc stopped", 1'b1, power_out.osc_stop)
        `CHK("ram low", 1'b1, power_out.ram_low_power)
        wr(PWR, 8'h00);
        rdchk("sleep kept", PWR, 8'h01);
        n = rst_cnt;
        repeat (80 * T) @(posedge sys_clk);
        `CHK("sleep suspends dog", n, rst_cnt)
        force_short_wake();
        `CHK("short wake ignored", 0, irq_cnt)
        rdchk("still asleep", PWR, 8'h01);
        @(posedge sys_clk);
        wake_len   <= 16'(W + 2);
        wake_start <= 1'b1;
        @(posedge sys_clk);
        wake_start <= 1'b0;
        t0 = $time;
        n = 0;
        while (wake_irq !== 1'b1 && n < 50) begin
            n++;
            @(posedge sys_clk);
        end
        `CHK("wake delay", 1'b1, n >= W && n <= W + 3)
        repeat (3) @(posedge sys_clk);
        `CHK("one wake pulse", 1, irq_cnt)
        `CHK("osc running", 1'b0, power_out.osc_stop)
        rdchk("awake", PWR, 8'h00);
        t0 = $time;
        wait_dog();
        `CHK("dog resumed", 1'b1, mcu_reset)
        rdchk("enable survives", DCS, 8'hc0);
        usb_reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        usb_reset <= 1'b0;
        rdchk("usb reset off", DCS, 8'hc0);
        wr(CFG, 8'h01);
        rdchk("config rw", CFG, 8'h01);
        usb_reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        usb_reset <= 1'b0;
        rdchk("usb reset clears", DCS, 8'h00);
        wr(PWR, 8'h8c);
        wr(DCS, 8'h80);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rdchk("power after rst", PWR, 8'h00);
        rdchk("dog after rst", DCS, 8'h00);
        conclude();
    end

    // Two holds one cycle short of the filter, a low gap between them
    task automatic force_short_wake();
        @(posedge sys_clk);
        wake_len   <= 16'(W - 1);
        wake_start <= 1'b1;
        @(posedge sys_clk);
        wake_start <= 1'b0;
        repeat (W + 1) @(posedge sys_clk);
        wake_start <= 1'b1;
        @(posedge sys_clk);
        wake_start <= 1'b0;
        repeat (W + 8) @(posedge sys_clk);
    endtask
endmodule

`default_nettype wire
